// ==== core/rtcdt_pkg.sv ====
// Package of constants and types for the calendar date register block.
package rtcdt_pkg;

	localparam logic [11:0] CALENDAR_DATE_VALUE_OFFS = 12'h000;
	localparam logic [11:0] CLOCK_CONTROL_WORD_OFFS  = 12'h004;
	localparam int          CLOCK_WRITE_ENABLE_BIT   = 3;

	localparam int YEAR_TENS_MSB    = 31;
	localparam int YEAR_TENS_LSB    = 28;
	localparam int YEAR_UNITS_MSB   = 27;
	localparam int YEAR_UNITS_LSB   = 24;
	localparam int MONTH_TENS_POS   = 20;
	localparam int MONTH_UNITS_MSB  = 19;
	localparam int MONTH_UNITS_LSB  = 16;
	localparam int MDAY_TENS_MSB    = 13;
	localparam int MDAY_TENS_LSB    = 12;
	localparam int MDAY_UNITS_MSB   = 11;
	localparam int MDAY_UNITS_LSB   = 8;
	localparam int WEEKDAY_MSB      = 2;
	localparam int WEEKDAY_LSB      = 0;

	localparam logic [31:0] DATE_IMPL_MASK = 32'hff1f3f07;
	localparam logic [31:0] DATE_RESET     = 32'h00000000;
	localparam logic        CTRL_RESET     = 1'b0;

	typedef struct packed {
		logic [3:0] year_tens_digit;
		logic [3:0] year_units_digit;
		logic [2:0] pad_a;
		logic       month_tens_digit;
		logic [3:0] month_units_digit;
		logic [1:0] pad_b;
		logic [1:0] monthday_tens_digit;
		logic [3:0] monthday_units_digit;
		logic [4:0] pad_c;
		logic [2:0] weekday_code;
	} rtcdt_date_t;

	typedef enum logic [1:0] {
		RTCDT_IDLE   = 2'b00,
		RTCDT_ACCESS = 2'b01
	} rtcdt_state_t;

endpackage

// ==== core/rtcdt_regs.sv ====
// Calendar date holding register with clock control word, as an APB slave.
//
// Operation
// - Year tens digit in bits 31..28.
// - Year units digit in bits 27..24.
// - Month tens digit in bit 20.
// - Month units digit in bits 19..16.
// - Day tens digit in bits 13..12.
// - Day units digit in bits 11..8.
// - Weekday code in bits 2..0.
// - Unused bits read zero, not stored.
// - Date writes only when write enable set.
// - Date contents undefined until software writes; this block resets them to zero.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module rtcdt_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        clock_write_enable,
	output var  rtcdt_pkg::rtcdt_date_t calendar_date_value
);

	// The date has no defined power-up value; a fixed zero keeps simulation free of unknowns,
	// while software must still treat the value as meaningless until it has written it.
	localparam rtcdt_pkg::rtcdt_date_t RESET_FIELDS = rtcdt_pkg::DATE_RESET;

	rtcdt_pkg::rtcdt_state_t state_r;
	rtcdt_pkg::rtcdt_state_t state_nxt;
	logic                    pready_nxt;
	logic [31:0]             prdata_nxt;
	logic                    pslverr_nxt;
	logic                    hit_date;
	logic                    hit_ctrl;
	logic                    hit_any;
	logic                    setup;
	logic                    wr_now;
	logic                    wr_ctrl;
	logic                    date_accept;
	logic [31:0]             ctrl_word;
	logic [31:0]             read_word;

	logic                    ctrl_we_r;
	logic                    ctrl_we_nxt;
	logic [3:0]              year_tens_r;
	logic [3:0]              year_tens_nxt;
	logic [3:0]              year_units_r;
	logic [3:0]              year_units_nxt;
	logic                    month_tens_r;
	logic                    month_tens_nxt;
	logic [3:0]              month_units_r;
	logic [3:0]              month_units_nxt;
	logic [1:0]              mday_tens_r;
	logic [1:0]              mday_tens_nxt;
	logic [3:0]              mday_units_r;
	logic [3:0]              mday_units_nxt;
	logic [2:0]              weekday_r;
	logic [2:0]              weekday_nxt;

	rtcdt_pkg::rtcdt_date_t  date_word;
	rtcdt_pkg::rtcdt_date_t  date_view_nxt;
	logic                    write_enable_nxt;

	// Only the two mapped words decode; any other address answers with an error and changes nothing.
	always_comb begin
		hit_date = 1'b0;
		hit_ctrl = 1'b0;
		case (paddr)
			rtcdt_pkg::CALENDAR_DATE_VALUE_OFFS: begin
				hit_date = 1'b1;
			end
			rtcdt_pkg::CLOCK_CONTROL_WORD_OFFS: begin
				hit_ctrl = 1'b1;
			end
			default: begin
				hit_date = 1'b0;
				hit_ctrl = 1'b0;
			end
		endcase
		hit_any = hit_date || hit_ctrl;
	end

	always_comb begin
		setup       = psel && !penable && (state_r == rtcdt_pkg::RTCDT_IDLE);
		wr_now      = psel && penable && pready && pwrite;
		wr_ctrl     = wr_now && hit_ctrl;
		date_accept = wr_now && hit_date && ctrl_we_r;
	end

	// One wait-free access phase: pready rises in the cycle after setup.
	always_comb begin
		state_nxt  = state_r;
		pready_nxt = 1'b0;
		case (state_r)
			rtcdt_pkg::RTCDT_IDLE: begin
				if (setup) begin
					state_nxt  = rtcdt_pkg::RTCDT_ACCESS;
					pready_nxt = 1'b1;
				end
			end
			rtcdt_pkg::RTCDT_ACCESS: begin
				state_nxt  = rtcdt_pkg::RTCDT_IDLE;
				pready_nxt = 1'b0;
			end
			default: begin
				state_nxt  = rtcdt_pkg::RTCDT_IDLE;
				pready_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= rtcdt_pkg::RTCDT_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= pready_nxt;
		end
	end

	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[rtcdt_pkg::CLOCK_WRITE_ENABLE_BIT] = ctrl_we_r;
	end

	// Unused positions are tied to zero here and have no storage behind them.
	always_comb begin
		date_word                      = '0;
		date_word.year_tens_digit      = year_tens_r;
		date_word.year_units_digit     = year_units_r;
		date_word.month_tens_digit     = month_tens_r;
		date_word.month_units_digit    = month_units_r;
		date_word.monthday_tens_digit  = mday_tens_r;
		date_word.monthday_units_digit = mday_units_r;
		date_word.weekday_code         = weekday_r;
	end

	always_comb begin
		read_word = 32'h00000000;
		if (hit_date) begin
			read_word = date_word;
		end else if (hit_ctrl) begin
			read_word = ctrl_word;
		end
	end

	// Read data and error are captured at setup so both come from flip-flops.
	always_comb begin
		prdata_nxt  = 32'h00000000;
		pslverr_nxt = 1'b0;
		if (setup) begin
			pslverr_nxt = !hit_any;
			if (!pwrite) begin
				prdata_nxt = read_word;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= prdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_nxt;
		end
	end

	always_comb begin
		if (wr_ctrl) begin
			ctrl_we_nxt = pwdata[rtcdt_pkg::CLOCK_WRITE_ENABLE_BIT];
		end else begin
			ctrl_we_nxt = ctrl_we_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_we_r <= rtcdt_pkg::CTRL_RESET;
		end else begin
			ctrl_we_r <= ctrl_we_nxt;
		end
	end

	always_comb begin
		if (date_accept) begin
			year_tens_nxt = pwdata[rtcdt_pkg::YEAR_TENS_MSB:rtcdt_pkg::YEAR_TENS_LSB];
		end else begin
			year_tens_nxt = year_tens_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			year_tens_r <= RESET_FIELDS.year_tens_digit;
		end else begin
			year_tens_r <= year_tens_nxt;
		end
	end

	always_comb begin
		if (date_accept) begin
			year_units_nxt = pwdata[rtcdt_pkg::YEAR_UNITS_MSB:rtcdt_pkg::YEAR_UNITS_LSB];
		end else begin
			year_units_nxt = year_units_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			year_units_r <= RESET_FIELDS.year_units_digit;
		end else begin
			year_units_r <= year_units_nxt;
		end
	end

	always_comb begin
		if (date_accept) begin
			month_tens_nxt = pwdata[rtcdt_pkg::MONTH_TENS_POS];
		end else begin
			month_tens_nxt = month_tens_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			month_tens_r <= RESET_FIELDS.month_tens_digit;
		end else begin
			month_tens_r <= month_tens_nxt;
		end
	end

	always_comb begin
		if (date_accept) begin
			month_units_nxt = pwdata[rtcdt_pkg::MONTH_UNITS_MSB:rtcdt_pkg::MONTH_UNITS_LSB];
		end else begin
			month_units_nxt = month_units_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			month_units_r <= RESET_FIELDS.month_units_digit;
		end else begin
			month_units_r <= month_units_nxt;
		end
	end

	always_comb begin
		if (date_accept) begin
			mday_tens_nxt = pwdata[rtcdt_pkg::MDAY_TENS_MSB:rtcdt_pkg::MDAY_TENS_LSB];
		end else begin
			mday_tens_nxt = mday_tens_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mday_tens_r <= RESET_FIELDS.monthday_tens_digit;
		end else begin
			mday_tens_r <= mday_tens_nxt;
		end
	end

	always_comb begin
		if (date_accept) begin
			mday_units_nxt = pwdata[rtcdt_pkg::MDAY_UNITS_MSB:rtcdt_pkg::MDAY_UNITS_LSB];
		end else begin
			mday_units_nxt = mday_units_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mday_units_r <= RESET_FIELDS.monthday_units_digit;
		end else begin
			mday_units_r <= mday_units_nxt;
		end
	end

	always_comb begin
		if (date_accept) begin
			weekday_nxt = pwdata[rtcdt_pkg::WEEKDAY_MSB:rtcdt_pkg::WEEKDAY_LSB];
		end else begin
			weekday_nxt = weekday_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			weekday_r <= RESET_FIELDS.weekday_code;
		end else begin
			weekday_r <= weekday_nxt;
		end
	end

	always_comb begin
		date_view_nxt = date_word;
	end

	always_comb begin
		write_enable_nxt = ctrl_we_r;
	end

	// Visible copies come straight from flip-flops and trail the stored value by one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calendar_date_value <= '0;
		end else begin
			calendar_date_value <= date_view_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_write_enable <= 1'b0;
		end else begin
			clock_write_enable <= write_enable_nxt;
		end
	end

endmodule // rtcdt_regs

`default_nettype wire

// ==== verification/rtcdt_chk.sv ====
// Assertions for the calendar date register block.
`timescale 1ns/100ps
`default_nettype none
module rtcdt_chk (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   clock_write_enable,
	input wire rtcdt_pkg::rtcdt_date_t calendar_date_value
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] wd;
	wire  [31:0] cv = calendar_date_value;
	wire         we = clock_write_enable;
	wire         wr = pready && pwrite && !pslverr;
	wire         dw = wr && paddr == 12'h000;
	// Write data is kept because the register copies lag the write by two cycles.
	always_ff @(posedge pclk) if (wr) wd <= pwdata;
	property p_yr; dw && we |=> ##1 cv[31:24] == wd[31:24]; endproperty
	a_yr: assert property (p_yr) else $error("year");
	property p_mo; dw && we |=> ##1 cv[20:16] == wd[20:16]; endproperty
	a_mo: assert property (p_mo) else $error("month");
	property p_dy; dw && we |=> ##1 cv[13:8] == wd[13:8]; endproperty
	a_dy: assert property (p_dy) else $error("day");
	property p_wk; dw && we |=> ##1 cv[2:0] == wd[2:0]; endproperty
	a_wk: assert property (p_wk) else $error("weekday");
	property p_uz; (cv & 32'h00e0c0f8) == 32'h0; endproperty
	a_uz: assert property (p_uz) else $error("unused");
	// Only the date word is held to this mask; the control word legitimately shows its enable bit in bit 3, which the mask covers.
	property p_rz; pready && !pwrite && paddr == 12'h000 |-> (prdata & 32'h00e0c0f8) == 32'h0; endproperty
	a_rz: assert property (p_rz) else $error("read");
	property p_lk; dw && !we |=> ##1 cv == $past(cv, 2); endproperty
	a_lk: assert property (p_lk) else $error("lock");
	property p_en; wr && paddr == 12'h004 |=> ##1 we == wd[3]; endproperty
	a_en: assert property (p_en) else $error("enable");
	c_wr: cover property (dw && we);
	c_lk: cover property (dw && !we);
	c_rd: cover property (pready && !pwrite);
endmodule // rtcdt_chk
bind rtcdt_regs rtcdt_chk u_chk (.pclk, .presetn, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.clock_write_enable, .calendar_date_value);
`default_nettype wire

// ==== verification/testbench.sv ====
// Testbench for the calendar date register block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic                   pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic                   pready, pslverr, clock_write_enable, er;
	logic [11:0]            paddr = 12'h0;
	logic [31:0]            pwdata = 32'h0, prdata, rd;
	rtcdt_pkg::rtcdt_date_t calendar_date_value;
	int                     err_count = 0, n_tests = 0;
	rtcdt_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.clock_write_enable, .calendar_date_value);
	initial forever #50 pclk = ~pclk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		if (err_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// The wait has no limit of its own; a slave that never answers is ended by the watchdog.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h004, 32'hffffffff);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h8);
		chk({31'h0, clock_write_enable}, 32'h1);
		apb(1'b1, 12'h000, 32'h25f2f1fe);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h25123106);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h25123106);
		chk(calendar_date_value, 32'h25123106);
		chk({31'h0, clock_write_enable}, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0, er}, 32'h1);
		tally_and_finish;
	end
	initial begin
		#200000;
		err_count++;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
